/* design/pin_sync.sv */
// Two-flop synchroniser for a group of asynchronous pins
`timescale 1ns/100ps
module pin_sync #(
  parameter int WIDTH = 3,
  parameter logic [WIDTH-1:0] IDLE = '0
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_r;

  // First stage only feeds the second stage; reset to the idle levels so no false edge follows reset
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= IDLE;
      sync_out <= IDLE;
    end else begin
      meta_r <= async_in;
      sync_out <= meta_r;
    end
  end
endmodule

/* design/secreg_consts.svh */
// Opcodes, address fields and timing constants of the security-register command block
`ifndef SECREG_CONSTS_SVH
`define SECREG_CONSTS_SVH
`define OP_SR_ERASE 8'h44
`define OP_SR_PROG 8'h42
`define OP_SR_READ 8'h48
`define OP_RST_EN 8'h66
`define OP_RST 8'h99
`define ADDR_HI_ZERO 8'h00
`define ADDR_MID_ZERO 4'h0
`define SEL_REG1 4'h1
`define SEL_REG3 4'h3
`define BYTE_ERASED 8'hff
`define BYTE_LAST 8'hff
`define BITS_OPCODE 6'd8
`define BITS_ADDR_END 6'd32
`define BITS_DUMMY_END 6'd40
`define BITS_CNT_TOP 6'h3f
`define BITS_CNT_FOLD 6'h38
`define PINS_IDLE 3'h4
`define RST_TIME_NS 30000
`define SECREG_ERASE_TIME_NS 200000
`define SYS_CLK_NS 40
`endif

/* design/secreg_flash_ctrl.sv */
// Security-register erase/program/read and two-step software reset inside a serial flash
`timescale 1ns/100ps
`include "secreg_consts.svh"
// Overview of operation
// - Erase opcode 44h is accepted only while the write-enable latch is set.
// - Erase address: top byte 00h, bits 15:12 pick register 1-3, bits 11:8 zero.
// - Erase runs only if chip select rises exactly after the last address byte.
// - Erase is self-timed after chip select rises; busy is high meanwhile.
// - Finished erase clears the write-enable latch.
// - A set lock bit makes erase and program to that register ignored.
// - Program 42h needs write enable, address, 1 to 256 bytes from address low byte.
// - Read 48h takes address and eight dummy clocks, then data flows out.
// - Input sampled on rising clock; output shifted on falling clock, MSB first.
// - Read address increments per byte and wraps FFh to 00h in the register.
// - Reset happens only for 66h immediately followed by 99h.
// - Any other command after 66h cancels the reset-enable state.
// - Accepted reset aborts operations and clears volatile status bits; 66h is ignored while busy, so a running erase always completes.
// - Reset takes about 30us and no command is accepted meanwhile.
module secreg_flash_ctrl
  import secreg_pkg::*;
#(
  parameter int SECREG_ERASE_CYC = `SECREG_ERASE_TIME_NS / `SYS_CLK_NS,
  parameter int RST_CYC = `RST_TIME_NS / `SYS_CLK_NS,
  parameter int NREG = 3
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic chipSel_n,
  input wire logic serialClk,
  input wire logic serial_in,
  output logic serialOut,
  output logic serialOutEn,
  input wire logic setWriteEnable,
  input wire logic [NREG-1:0] lockSet,
  output logic write_enable_latch,
  output logic [NREG-1:0] otp_lock_bits,
  output logic erase_program_paused_flag,
  output logic [7:0] read_parameter_bits,
  output logic [2:0] wrap_setting_bits,
  output logic busy,
  output logic resetActive
);
  import secreg_pkg::*;

  logic [2:0] syncPins;
  logic csN;
  logic sck;
  logic sdi;
  logic sckPrev_r;
  logic csPrev_r;
  logic sckRise;
  logic sckFall;
  logic csRise;
  logic [5:0] bitCnt_r;
  logic [31:0] shift_r;
  logic [7:0] opcode_r;
  logic [23:0] addr_r;
  logic [7:0] byteAddr_r;
  logic [7:0] dataIn_r;
  logic [7:0] outByte_r;
  logic [2:0] outBit_r;
  logic rstEnable_r;
  logic [NREG-1:0][255:0][7:0] mem_r;
  oper_t oper_r;
  logic [1:0] operReg_r;
  logic [31:0] timer_r;
  logic busyAny;
  logic [1:0] regIdx;
  logic addrOk;

  // Pins cross into sys_clk through two flops before use
  pin_sync #(.WIDTH(3), .IDLE(`PINS_IDLE)) u_sync (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .async_in({chipSel_n, serialClk, serial_in}),
    .sync_out(syncPins)
  );
  assign csN = syncPins[2];
  assign sck = syncPins[1];
  assign sdi = syncPins[0];

  // Decode of register select field, used by erase, program and read
  function automatic logic selValid(input logic [23:0] a);
    selValid = (a[23:16] == `ADDR_HI_ZERO) && (a[11:8] == `ADDR_MID_ZERO) &&
      (a[15:12] >= `SEL_REG1) && (a[15:12] <= `SEL_REG3);
  endfunction

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sckPrev_r <= 1'b0;
      csPrev_r <= 1'b1;
    end else begin
      sckPrev_r <= sck;
      csPrev_r <= csN;
    end
  end
  assign sckRise = !csN && sck && !sckPrev_r;
  assign sckFall = !csN && !sck && sckPrev_r;
  assign csRise = csN && !csPrev_r;
  assign busyAny = (oper_r != OP_NONE);
  assign regIdx = 2'(addr_r[15:12] - `SEL_REG1);
  assign addrOk = selValid(addr_r);

  // Input shifter: sample on rising link clock, count bits of the frame
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      bitCnt_r <= '0;
      shift_r <= '0;
      opcode_r <= '0;
      addr_r <= '0;
    end else if (csN) begin
      bitCnt_r <= '0;
    end else if (sckRise) begin
      shift_r <= {shift_r[30:0], sdi};
      if (bitCnt_r == `BITS_CNT_TOP) begin
        bitCnt_r <= `BITS_CNT_FOLD; // Fold back one byte so the byte phase survives long frames
      end else begin
        bitCnt_r <= bitCnt_r + 6'h01;
      end
      if (bitCnt_r == `BITS_OPCODE - 6'h01) begin
        opcode_r <= {shift_r[6:0], sdi};
      end
      if (bitCnt_r == `BITS_ADDR_END - 6'h01) begin
        addr_r <= {shift_r[22:0], sdi};
      end
    end
  end

  // Reset-enable latch: only 66h then 99h resets, anything else disarms
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rstEnable_r <= 1'b0;
    end else if (sckRise && !busyAny && bitCnt_r == `BITS_OPCODE - 6'h01) begin
      rstEnable_r <= ({shift_r[6:0], sdi} == `OP_RST_EN);
    end else if (oper_r == OP_RESET) begin
      rstEnable_r <= 1'b0;
    end
  end

  // Operation sequencer with self-timed erase and reset recovery
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      oper_r <= OP_NONE;
      operReg_r <= '0;
      timer_r <= '0;
    end else if (oper_r == OP_RESET) begin
      if (timer_r == 32'(RST_CYC - 1)) begin
        oper_r <= OP_NONE;
      end
      timer_r <= timer_r + 32'h1;
    end else if (sckRise && rstEnable_r && bitCnt_r == `BITS_OPCODE - 6'h01 &&
                 {shift_r[6:0], sdi} == `OP_RST) begin
      oper_r <= OP_RESET;
      timer_r <= '0;
    end else if (oper_r == OP_ERASE) begin
      if (timer_r == 32'(SECREG_ERASE_CYC - 1)) begin
        oper_r <= OP_NONE;
      end
      timer_r <= timer_r + 32'h1;
    end else if (oper_r == OP_NONE && csRise && opcode_r == `OP_SR_ERASE &&
                 bitCnt_r == `BITS_ADDR_END && write_enable_latch && addrOk &&
                 !otp_lock_bits[regIdx]) begin
      oper_r <= OP_ERASE;
      operReg_r <= regIdx;
      timer_r <= '0;
    end
  end

  // Program bytes land immediately; erase fills the register at its end
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      dataIn_r <= '0;
      byteAddr_r <= '0;
      for (int r = 0; r < NREG; r++) begin
        mem_r[r] <= {256{`BYTE_ERASED}};
      end
    end else begin
      if (oper_r == OP_ERASE && timer_r == 32'(SECREG_ERASE_CYC - 1)) begin
        mem_r[operReg_r] <= {256{`BYTE_ERASED}};
      end
      if (sckRise && bitCnt_r == `BITS_ADDR_END - 6'h01) begin
        byteAddr_r <= {shift_r[6:0], sdi};
      end else if (sckRise && !busyAny && opcode_r == `OP_SR_PROG && write_enable_latch &&
                   addrOk && !otp_lock_bits[regIdx] && bitCnt_r >= `BITS_ADDR_END &&
                   bitCnt_r[2:0] == 3'h7) begin
        mem_r[regIdx][byteAddr_r] <= mem_r[regIdx][byteAddr_r] & {dataIn_r[6:0], sdi};
        byteAddr_r <= byteAddr_r + 8'h01;
      end else if (sckRise && opcode_r == `OP_SR_READ && bitCnt_r >= `BITS_DUMMY_END &&
                   bitCnt_r[2:0] == 3'h7) begin
        byteAddr_r <= byteAddr_r + 8'h01; // wraps FFh to 00h
      end
      if (sckRise) begin
        dataIn_r <= {dataIn_r[6:0], sdi};
      end
    end
  end

  // Read output: load on first fall of each byte slot, shift MSB first on falls
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      outByte_r <= '0;
      outBit_r <= '0;
      serialOut <= 1'b0;
      serialOutEn <= 1'b0;
    end else if (csN) begin
      serialOutEn <= 1'b0;
      outBit_r <= '0;
    end else if (sckFall && !busyAny && opcode_r == `OP_SR_READ && addrOk &&
                 bitCnt_r >= `BITS_DUMMY_END) begin
      serialOutEn <= 1'b1;
      if (outBit_r == 3'h0) begin
        serialOut <= mem_r[regIdx][byteAddr_r][7];
        outByte_r <= {mem_r[regIdx][byteAddr_r][6:0], 1'b0};
      end else begin
        serialOut <= outByte_r[7];
        outByte_r <= {outByte_r[6:0], 1'b0};
      end
      outBit_r <= outBit_r + 3'h1;
    end
  end

  // Status flags; lock bits are one-way and survive the software reset
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      write_enable_latch <= 1'b0;
      otp_lock_bits <= '0;
      erase_program_paused_flag <= 1'b0;
      read_parameter_bits <= '0;
      wrap_setting_bits <= '0;
      busy <= 1'b0;
      resetActive <= 1'b0;
    end else begin
      otp_lock_bits <= otp_lock_bits | lockSet;
      busy <= busyAny;
      resetActive <= (oper_r == OP_RESET);
      if (oper_r == OP_RESET) begin
        write_enable_latch <= 1'b0;
        erase_program_paused_flag <= 1'b0;
        read_parameter_bits <= '0;
        wrap_setting_bits <= '0;
      end else if (oper_r == OP_ERASE && timer_r == 32'(SECREG_ERASE_CYC - 1)) begin
        write_enable_latch <= 1'b0;
      end else if (setWriteEnable && !busyAny) begin
        write_enable_latch <= 1'b1;
      end else if (csRise && opcode_r == `OP_SR_PROG && bitCnt_r > `BITS_ADDR_END) begin
        write_enable_latch <= 1'b0;
      end
    end
  end
endmodule

/* design/secreg_pkg.sv */
// Types shared by the security-register command block
package secreg_pkg;
  typedef enum {
    CMD_IDLE,
    CMD_OTHER,
    CMD_ERASE,
    CMD_PROG,
    CMD_READ
  } cmd_t;
  typedef enum {
    OP_NONE,
    OP_ERASE,
    OP_PROG,
    OP_RESET
  } oper_t;
endpackage

/* verification/host_model.sv */
// Host SPI controller model driving select, serial clock and data
`timescale 1ns/100ps
module host_model (
  input wire logic sys_clk,
  input wire logic serialOut,
  output logic chipSel_n,
  output logic serialClk,
  output logic serial_in
);
  initial begin
    chipSel_n = 1'b1;
    serialClk = 1'b0;
    serial_in = 1'b0;
  end
  // Select stays low for the whole frame and rises only after its last byte
  task automatic sel(input logic on);
    repeat (4) @(posedge sys_clk);
    chipSel_n <= !on;
    if (!on) begin
      serial_in <= !serial_in;
      repeat (4) @(posedge sys_clk);
      serialClk <= 1'b0;
    end
    repeat (4) @(posedge sys_clk);
  endtask
  // Data set while low; read bit taken just before the next fall, 320 ns per bit
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      serialClk <= 1'b0;
      serial_in <= tx[i];
      repeat (4) @(posedge sys_clk);
      serialClk <= 1'b1;
      repeat (4) @(posedge sys_clk);
      rx[i] = serialOut;
    end
  endtask
endmodule

/* verification/secreg_asserts.sv */
// Port-level checks for the security-register command block
`timescale 1ns/100ps
module secreg_asserts #(
  parameter int SECREG_ERASE_CYC = 20,
  parameter int RST_CYC = 10,
  parameter int NREG = 3
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic chipSel_n,
  input wire logic serialOutEn,
  input wire logic write_enable_latch,
  input wire logic [NREG-1:0] otp_lock_bits,
  input wire logic erase_program_paused_flag,
  input wire logic [7:0] read_parameter_bits,
  input wire logic [2:0] wrap_setting_bits,
  input wire logic busy,
  input wire logic resetActive
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  int busyCnt_r;
  // Length of the current busy stretch, so long counts need no repetition
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) busyCnt_r <= 0;
    else busyCnt_r <= busy ? busyCnt_r + 1 : 0;
  end
  property p_eraseWel; $rose(busy) && !resetActive |-> write_enable_latch; endproperty
  a_eraseWel: assert property (p_eraseWel) else $error("erase without latch");
  property p_eraseCs; $rose(busy) && !resetActive |-> chipSel_n && !serialOutEn; endproperty
  a_eraseCs: assert property (p_eraseCs) else $error("erase began while selected");
  property p_eraseEnd; $fell(busy) |-> !$past(write_enable_latch); endproperty
  a_eraseEnd: assert property (p_eraseEnd) else $error("latch kept after erase");
  property p_busyMax; busyCnt_r <= SECREG_ERASE_CYC + RST_CYC + 4; endproperty
  a_busyMax: assert property (p_busyMax) else $error("busy too long");
  property p_rstClr;
    $rose(resetActive) |-> ##[1:2] (!write_enable_latch && !erase_program_paused_flag
      && read_parameter_bits == 8'h00 && wrap_setting_bits == 3'h0);
  endproperty
  a_rstClr: assert property (p_rstClr) else $error("state kept over reset");
  property p_rstBusy; resetActive |-> busy; endproperty
  a_rstBusy: assert property (p_rstBusy) else $error("ready during reset");
  property p_rstLen; $fell(resetActive) |-> $past(busyCnt_r) >= RST_CYC - 2; endproperty
  a_rstLen: assert property (p_rstLen) else $error("reset too short");
  property p_oeCs; serialOutEn |-> !$past(chipSel_n, 5); endproperty
  a_oeCs: assert property (p_oeCs) else $error("driving while deselected");
  property p_lock; ($past(otp_lock_bits) & ~otp_lock_bits) == '0; endproperty
  a_lock: assert property (p_lock) else $error("lock bit cleared");
endmodule
bind secreg_flash_ctrl secreg_asserts #(.SECREG_ERASE_CYC(SECREG_ERASE_CYC), .RST_CYC(RST_CYC), .NREG(NREG))
  u_secreg_asserts (.sys_clk(sys_clk), .rst_n(rst_n), .chipSel_n(chipSel_n), .serialOutEn(serialOutEn),
  .write_enable_latch(write_enable_latch), .otp_lock_bits(otp_lock_bits),
  .erase_program_paused_flag(erase_program_paused_flag), .read_parameter_bits(read_parameter_bits),
  .wrap_setting_bits(wrap_setting_bits), .busy(busy), .resetActive(resetActive));

/* verification/testbench.sv */
// Self-checking bench for the security-register command block
`timescale 1ns/100ps
`include "secreg_consts.svh"
module testbench;
  import secreg_pkg::*;
  logic sys_clk = 1'b0;
  logic rst_n, setWriteEnable, chipSel_n, serialClk, serial_in, serialOut, serialOutEn;
  logic write_enable_latch, erase_program_paused_flag, busy, resetActive;
  logic [2:0] lockSet, otp_lock_bits, wrap_setting_bits;
  logic [7:0] read_parameter_bits, d0, d1, a;
  logic [7:0] r [$];
  logic [31:0] seed = 32'h32f6;
  int n_errors = 0;
  int check_count = 0;
  always #20 sys_clk = ~sys_clk;
  // Short erase and reset times keep the run brief
  secreg_flash_ctrl #(.SECREG_ERASE_CYC(40), .RST_CYC(40)) u_secreg_flash_ctrl (.*);
  host_model u_host_model (.*);
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Programming can only clear bits of an erased byte
  function automatic logic [7:0] expProg(input logic [7:0] old, input logic [7:0] d);
    return old & d;
  endfunction
  task automatic summarize();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
      n_errors++;
    end
  endtask
  task automatic runFrame(input logic [7:0] q [$]);
    logic [7:0] rx;
    r = {};
    u_host_model.sel(1'b1);
    foreach (q[i]) begin
      u_host_model.xfer(q[i], rx);
      r.push_back(rx);
    end
    u_host_model.sel(1'b0);
  endtask
  task automatic we();
    @(posedge sys_clk);
    setWriteEnable <= 1'b1;
    @(posedge sys_clk);
    setWriteEnable <= 1'b0;
  endtask
  task automatic waitIdle();
    for (int i = 0; i < 200 && busy !== 1'b0; i++) @(posedge sys_clk);
    chk({7'h0, busy}, 8'h0, "busy timeout");
    if (busy !== 1'b0) summarize();
  endtask
  initial begin
    rst_n = 1'b0;
    setWriteEnable = 1'b0;
    lockSet = 3'h0;
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    runFrame('{`OP_SR_ERASE, 8'h00, 8'h10, 8'h00});
    chk({7'h0, busy}, 8'h0, "erase without latch");
    // Wrap corner at FFh first, then a random start in another register
    for (int k = 0; k < 2; k++) begin
      seed = lfsr(seed);
      d0 = seed[7:0];
      d1 = seed[15:8];
      a = k ? seed[23:16] : `BYTE_LAST;
      we();
      runFrame('{`OP_SR_PROG, 8'h00, {k ? `SEL_REG3 : `SEL_REG1, `ADDR_MID_ZERO}, a, d0, d1});
      runFrame('{`OP_SR_READ, 8'h00, {k ? `SEL_REG3 : `SEL_REG1, `ADDR_MID_ZERO}, a, seed[31:24], 8'h5a, 8'ha5});
      chk(r[5], expProg(`BYTE_ERASED, d0), "first byte");
      chk(r[6], expProg(`BYTE_ERASED, d1), "next byte");
    end
    $display("test program and read done");
    // Frames longer than the bit counter's top must keep every byte in its slot
    seed = lfsr(seed);
    we();
    runFrame('{`OP_SR_PROG, 8'h00, 8'h20, 8'hfe, seed[7:0], seed[15:8], seed[23:16], seed[31:24], ~seed[7:0]});
    runFrame('{`OP_SR_READ, 8'h00, 8'h20, 8'hfe, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00});
    for (int i = 0; i < 5; i++) begin
      chk(r[5 + i], i < 4 ? seed[8*i +: 8] : ~seed[7:0], "long frame byte");
    end
    $display("test long frames done");
    we();
    runFrame('{`OP_SR_ERASE, 8'h00, 8'h10, 8'h00, 8'h00});
    chk({7'h0, busy}, 8'h0, "late select rise");
    runFrame('{`OP_SR_ERASE, 8'h00, 8'h10, 8'h00});
    chk({7'h0, busy}, 8'h1, "erase busy");
    waitIdle();
    chk({7'h0, write_enable_latch}, 8'h0, "latch after erase");
    runFrame('{`OP_SR_READ, 8'h00, 8'h10, `BYTE_LAST, 8'h00, 8'h00, 8'h00});
    chk(r[5] & r[6], `BYTE_ERASED, "erased bytes");
    $display("test erase done");
    lockSet <= 3'h2;
    @(posedge sys_clk);
    lockSet <= 3'h0;
    we();
    runFrame('{`OP_SR_PROG, 8'h00, 8'h20, 8'h07, 8'h00});
    runFrame('{`OP_SR_READ, 8'h00, 8'h20, 8'h07, 8'h00, 8'h00});
    chk(r[5], `BYTE_ERASED, "locked register");
    chk({5'h0, otp_lock_bits}, 8'h02, "lock bit");
    $display("test lock done");
    we();
    chk({6'h0, busy, erase_program_paused_flag}, 8'h0, "idle before reset");
    runFrame('{`OP_RST_EN});
    runFrame('{`OP_SR_PROG});
    runFrame('{`OP_RST});
    chk({6'h0, resetActive, write_enable_latch}, 8'h1, "reset disarmed");
    runFrame('{`OP_RST_EN});
    runFrame('{`OP_RST});
    chk({6'h0, resetActive, write_enable_latch}, 8'h2, "reset taken");
    we();
    chk({7'h0, write_enable_latch}, 8'h0, "ignored during reset");
    waitIdle();
    chk({7'h0, resetActive}, 8'h0, "reset over");
    $display("test reset done");
    summarize();
  end
endmodule
